// ---- rtl/dmc_pkg.sv ----
// Package for the debug mode controller: constants, states and carriers.
// Assumes a 10 MHz core clock and a 32-bit cause/enable register pair.
package dmc_pkg;

  // Reset sampling delay
  localparam int unsigned ENTRY_SAMPLE_CYC = 8;   // second pin sample after release
  localparam logic [3:0]  ENTRY_SAMPLE_CNT = 4'(ENTRY_SAMPLE_CYC);

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_ENABLE  = 4'h0;  // debug_enable_reg
  localparam logic [3:0] OFS_CAUSE   = 4'h1;  // exception_cause_reg, clear on read
  localparam logic [3:0] OFS_STATUS  = 4'h2;  // mode and port status
  localparam logic [3:0] OFS_PORTDAT = 4'h3;  // port_data_reg
  localparam logic [3:0] OFS_MSTATE  = 4'h4;  // machine_state_reg allow bits

  // Cause / enable bit positions
  localparam int unsigned BIT_CHKSTOP = 29;  // machine check, allow clear
  localparam int unsigned BIT_MCHECK  = 28;  // machine check, allow set
  localparam int unsigned BIT_EXTIRQ  = 17;
  localparam int unsigned BIT_BRKPT   = 30;
  localparam logic [31:0] CAUSE_CHKSTOP = 32'h2000_0000;
  localparam logic [31:0] CAUSE_MCHECK  = 32'h1000_0000;

  // machine_state_reg allow bits
  localparam int unsigned MS_EXT_IRQ = 0;
  localparam int unsigned MS_MCHECK  = 1;

  // Reset values
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [1:0]  MSTATE_RST = 2'h0;

  // Pipeline flag codes
  localparam logic [1:0] FLAG_FREEZE = 2'h3;
  localparam logic [1:0] FLAG_IDLE   = 2'h0;

  // Port status codes shifted out
  localparam logic [1:0] ST_NULL   = 2'h0;
  localparam logic [1:0] ST_VALID  = 2'h1;
  localparam logic [1:0] ST_EXCEPT = 2'h2;
  localparam logic [1:0] ST_SEQERR = 2'h3;

  // Port transfer kinds from the serial front end
  typedef enum logic [1:0] {
    XK_INSTR = 2'h0,
    XK_DATA  = 2'h1,
    XK_TRAP  = 2'h2
  } dmc_xkind_t;

  // Processor run state, Gray along reset -> wait -> run -> debug
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_WAIT    = 3'b001,
    ST_RUN     = 3'b011,
    ST_DEBUG   = 3'b010,
    ST_CHKSTOP = 3'b110
  } dmc_state_t;

  // Word arriving from the serial port
  typedef struct packed {
    logic       valid;
    dmc_xkind_t kind;
    logic [31:0] data;
  } dmc_port_in_t;

  // Processor event lines
  typedef struct packed {
    logic        exc;      // exception pulse
    logic [31:0] cause;    // one-hot cause of it
    logic        ext_irq;  // external interrupt request level
    logic        mcheck;   // machine check pulse
    logic        rfi;      // return_from_interrupt executed
    logic        port_data_reg_wr;  // CPU writes port_data_reg
    logic        port_data_reg_rd;  // CPU wants to read port_data_reg
  } dmc_cpu_ev_t;

  // Cause bit that maps to each enable bit
  function automatic logic [31:0] dmc_hit(input logic [31:0] cause, input logic [31:0] en);
    dmc_hit = cause & en;
  endfunction

endpackage

// ---- rtl/dmc_pin_sync.sv ----
// Three-stage synchroniser for a pin from outside the clock domain.
// Output changes only once stages two and three agree.
`timescale 1ns/1ps
module dmc_pin_sync
  import dmc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin and result
  input  wire logic pin,
  output logic      level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a change only when the later stages agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      level_ff <= 1'b0;
    else if (s2_ff == s3_ff)
      level_ff <= s3_ff;
  end

  assign level = level_ff;

endmodule

// ---- rtl/dmc_port_data.sv ----
// Holding register for port_data_reg with registered read data.
// Assumes one writer per cycle; CPU writes win over port loads.
`timescale 1ns/1ps
module dmc_port_data
  import dmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Writers
  input  wire logic        cpu_wr,
  input  wire logic [31:0] cpu_wdata,
  input  wire logic        port_wr,
  input  wire logic [31:0] port_wdata,
  // Read side
  output logic [31:0]      rdata
);

  logic [31:0] word_ff;
  logic [31:0] rdata_ff;

  // Store: the CPU side has priority
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      word_ff <= 32'h0000_0000;
    else if (cpu_wr)
      word_ff <= cpu_wdata;
    else if (port_wr)
      word_ff <= port_wdata;
  end

  // Registered read data
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= word_ff;
  end

  assign rdata = rdata_ff;

endmodule

// ---- rtl/dmc_top.sv ----
// Debug mode controller: reset-time debug enable, entry, freeze and exit.
// Assumes a serial front end delivers decoded port words and takes status.
`timescale 1ns/1ps
// Functional notes
// - Serial clock pin level just before reset release enables or disables debug.
// - Pin resampled eight cycles after release; low means normal reset-vector run.
// - Pin still high with debug enabled: breakpoint entry before first instruction runs.
// - Breakpoint and watchpoint logic keeps working while debug is disabled.
// - Enter debug when enabled, an exception occurs and its enable bit is set.
// - On entry save return address and state, then fetch from the port.
// - Cause register records the event that caused debug entry.
// - In debug every fetch comes from the port; data moves through it too.
// - Prefetch is off in debug so data follows its instruction directly.
// - Exceptions in debug do not save or branch; they flag port exception status.
// - External interrupt in debug flags the same status when unmasked and allowed.
// - Freeze on debug entry, or monitor entry only while debug is disabled.
// - Freeze shows as code 11 on the pipeline flags throughout debug.
// - Return-from-interrupt in debug leaves debug and removes the freeze code.
// - Reading the cause register clears it; a pending enabled cause re-enters.
// - Machine check with allow clear: checkstop unless debug and checkstop enable.
// - Machine check with allow set: exception unless debug and mcheck enable.
// - In debug the shifted-in word sets activity and the next status out.
// - Outside debug only trap-enable data is taken; else sequence error next.
module dmc_top
  import dmc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Reset output of the chip, high while reset is driven
  input  wire logic         reset_output,
  // Development port pins and decoded words
  input  wire logic         dev_serial_clock_pin,
  input  wire dmc_port_in_t port_in,
  output logic [1:0]        port_status,
  output logic [31:0]       port_out_data,
  output logic [6:0]        trap_enable,
  // Processor events and controls
  input  wire dmc_cpu_ev_t  cpu_ev,
  input  wire logic [31:0]  cpu_wdata,
  output logic              fetch_from_port,
  output logic              prefetch_off,
  output logic              take_exception,
  output logic              save_context,
  output logic [31:0]       instr_to_cpu,
  output logic              instr_valid,
  output logic              checkstop,
  output logic              monitor_freeze,
  output logic [1:0]        pipeline_flag_pins,
  output logic              reset_vector_go,
  // Register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata
);

  logic        pin_lvl;
  logic        rst_lvl;
  logic        rst_lvl_d_ff;
  logic        dbg_en_ff;
  logic [3:0]  samp_cnt_ff;
  logic        samp_act_ff;
  dmc_state_t  state_ff;
  logic [31:0] enable_ff;
  logic [31:0] cause_ff;
  logic [1:0]  mstate_ff;
  logic        exc_flag_ff;
  logic        seq_err_ff;
  logic        valid_ff;
  logic [1:0]  status_ff;
  logic [6:0]  trap_ff;
  logic [31:0] instr_ff;
  logic        instr_vld_ff;
  logic        take_exc_ff;
  logic        save_ff;
  logic        chk_ff;
  logic        mon_frz_ff;
  logic [1:0]  flags_ff;
  logic        go_ff;
  logic [31:0] rdata_ff;
  logic [31:0] pd_rdata;
  logic        rel_edge;
  logic        in_dbg;
  logic        enter_dbg;
  logic        rd_cause;
  logic        mc_to_dbg;
  logic        mc_chk;
  logic        mc_exc;
  logic        exc_hit;
  logic        irq_dbg;
  logic        word_in;
  logic        word_bad;
  logic        port_data_wr;

  // Pins from outside the clock domain
  dmc_pin_sync u_sync_pin (
    .clk    (clk),
    .resetn (resetn),
    .pin    (dev_serial_clock_pin),
    .level  (pin_lvl)
  );

  dmc_pin_sync u_sync_rst (
    .clk    (clk),
    .resetn (resetn),
    .pin    (reset_output),
    .level  (rst_lvl)
  );

  // Port data register holds CPU data for shifting out and port data for reads
  dmc_port_data u_pdata (
    .clk        (clk),
    .resetn     (resetn),
    .cpu_wr     (cpu_ev.port_data_reg_wr & in_dbg),
    .cpu_wdata  (cpu_wdata),
    .port_wr    (port_data_wr),
    .port_wdata (port_in.data),
    .rdata      (pd_rdata)
  );

  // Common terms
  assign rel_edge  = rst_lvl_d_ff & ~rst_lvl;
  assign in_dbg    = (state_ff == ST_DEBUG);
  assign rd_cause  = reg_rd && (reg_addr == OFS_CAUSE);
  assign word_in   = port_in.valid && (state_ff != ST_RESET);
  assign word_bad  = port_in.kind != XK_TRAP && status_ff < ST_EXCEPT &&
                     (!in_dbg || (port_in.kind == XK_INSTR) == cpu_ev.port_data_reg_rd);
  // Machine check resolution
  assign mc_chk    = cpu_ev.mcheck && !mstate_ff[MS_MCHECK] &&
                     !(dbg_en_ff && enable_ff[BIT_CHKSTOP]);
  assign mc_exc    = cpu_ev.mcheck && mstate_ff[MS_MCHECK] &&
                     !(dbg_en_ff && enable_ff[BIT_MCHECK]);
  assign mc_to_dbg = cpu_ev.mcheck && dbg_en_ff && !mc_chk && !mc_exc;
  assign exc_hit   = cpu_ev.exc && (dmc_hit(cpu_ev.cause, enable_ff) != 32'h0);
  // Entry from run; a pending enabled cause re-enters straight after return
  assign enter_dbg = (state_ff == ST_RUN) && dbg_en_ff &&
                     (exc_hit || mc_to_dbg ||
                      (dmc_hit(cause_ff, enable_ff) != 32'h0));
  assign irq_dbg   = in_dbg && cpu_ev.ext_irq && !enable_ff[BIT_EXTIRQ] &&
                     mstate_ff[MS_EXT_IRQ];
  assign port_data_wr = in_dbg && word_in && port_in.kind == XK_DATA &&
                        cpu_ev.port_data_reg_rd;

  // Reset output delay for release edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_lvl_d_ff <= 1'b0;
    else
      rst_lvl_d_ff <= rst_lvl;
  end

  // Debug enable caught while reset is driven, frozen once it releases
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dbg_en_ff <= 1'b0;
    else if (rst_lvl)
      dbg_en_ff <= pin_lvl;                      // last sample before release
  end

  // Count eight cycles after release for the second sample
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      samp_cnt_ff <= 4'h0;
      samp_act_ff <= 1'b0;
    end
    else if (rst_lvl)
    begin
      samp_cnt_ff <= 4'h0;
      samp_act_ff <= 1'b0;
    end
    else if (rel_edge)
    begin
      samp_cnt_ff <= 4'h1;
      samp_act_ff <= 1'b1;
    end
    else if (samp_act_ff)
    begin
      samp_cnt_ff <= samp_cnt_ff + 4'h1;
      samp_act_ff <= (samp_cnt_ff != ENTRY_SAMPLE_CNT);
    end
  end

  // Run state machine
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_ff <= ST_RESET;
    else if (rst_lvl)
      state_ff <= ST_RESET;
    else
    begin
      case (state_ff)
        ST_RESET: state_ff <= ST_WAIT;
        ST_WAIT:
          if (samp_act_ff && samp_cnt_ff == ENTRY_SAMPLE_CNT)
            state_ff <= (pin_lvl && dbg_en_ff) ? ST_DEBUG : ST_RUN;
        ST_RUN:
          if (mc_chk)
            state_ff <= ST_CHKSTOP;
          else if (enter_dbg)
            state_ff <= ST_DEBUG;
        ST_DEBUG:
          if (cpu_ev.rfi)
            state_ff <= ST_RUN;
        ST_CHKSTOP: state_ff <= ST_CHKSTOP;
        default: state_ff <= ST_RESET;
      endcase
    end
  end

  // Software registers: enable and allow bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_ff <= ENABLE_RST;
      mstate_ff <= MSTATE_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_ENABLE)
        enable_ff <= reg_wdata;
      if (reg_addr == OFS_MSTATE)
        mstate_ff <= reg_wdata[1:0];
    end
  end

  // Cause register: events set, read clears, set wins over clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cause_ff <= 32'h0000_0000;
    else
    begin
      cause_ff <= (rd_cause ? 32'h0000_0000 : cause_ff)
                | (cpu_ev.exc ? cpu_ev.cause : 32'h0000_0000)
                | ((cpu_ev.mcheck && !mstate_ff[MS_MCHECK]) ? CAUSE_CHKSTOP : 32'h0)
                | ((cpu_ev.mcheck && mstate_ff[MS_MCHECK]) ? CAUSE_MCHECK : 32'h0)
                | ((state_ff == ST_WAIT && samp_cnt_ff == ENTRY_SAMPLE_CNT &&
                    pin_lvl && dbg_en_ff) ? (32'h1 << BIT_BRKPT) : 32'h0);
    end
  end

  // Exception status flag for the port; no save or branch in debug
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      exc_flag_ff <= 1'b0;
    else if ((in_dbg && (cpu_ev.exc || cpu_ev.mcheck)) || irq_dbg)
      exc_flag_ff <= 1'b1;
    else if (word_in && !valid_ff && !word_bad)
      exc_flag_ff <= 1'b0;
  end

  // Port word handling and next status
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_err_ff   <= 1'b0;
      valid_ff     <= 1'b0;
      status_ff    <= ST_NULL;
      trap_ff      <= 7'h00;
      instr_ff     <= 32'h0000_0000;
      instr_vld_ff <= 1'b0;
    end
    else
    begin
      instr_vld_ff <= 1'b0;
      if (word_in)
      begin
        // Status for the next frame; priority valid, seq, exc
        status_ff <= valid_ff ? ST_VALID : word_bad ? ST_SEQERR :
                     exc_flag_ff ? ST_EXCEPT : ST_NULL;
        valid_ff   <= 1'b0;
        seq_err_ff <= word_bad;
        if (status_ff == ST_SEQERR || status_ff == ST_EXCEPT)
          seq_err_ff <= 1'b0;                     // Word dropped while error shifts out; a data word still loads port_data_reg
        else if (port_in.kind == XK_TRAP)
          trap_ff <= port_in.data[6:0];           // Trap enables accepted in any mode
        else if (!in_dbg)
          seq_err_ff <= 1'b1;
        else if (port_in.kind == XK_INSTR && !cpu_ev.port_data_reg_rd)
        begin
          instr_ff     <= port_in.data;
          instr_vld_ff <= 1'b1;
        end
        else if ((port_in.kind == XK_INSTR) == cpu_ev.port_data_reg_rd)
          seq_err_ff <= 1'b1;
      end
      if (in_dbg && cpu_ev.port_data_reg_wr)
        valid_ff <= 1'b1;
    end
  end

  // Processor side controls and pipeline flags
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      take_exc_ff <= 1'b0;
      save_ff     <= 1'b0;
      chk_ff      <= 1'b0;
      mon_frz_ff  <= 1'b0;
      flags_ff    <= FLAG_IDLE;
      go_ff       <= 1'b0;
    end
    else
    begin
      // Normal exceptions run whether or not debug is enabled
      take_exc_ff <= (state_ff == ST_RUN) && !enter_dbg &&
                     (mc_exc || (cpu_ev.exc && !mc_chk));
      save_ff     <= (state_ff == ST_RUN) && (enter_dbg || cpu_ev.exc || mc_exc);
      chk_ff      <= (state_ff == ST_CHKSTOP) || mc_chk;
      go_ff       <= (state_ff == ST_WAIT) && samp_act_ff &&
                     samp_cnt_ff == ENTRY_SAMPLE_CNT;
      // Monitor freeze only with debug disabled
      if (!dbg_en_ff && state_ff == ST_RUN && exc_hit)
        mon_frz_ff <= 1'b1;
      else if (cpu_ev.rfi || dbg_en_ff)
        mon_frz_ff <= 1'b0;
      flags_ff <= ((in_dbg && !cpu_ev.rfi) || enter_dbg ||
                   (state_ff == ST_WAIT && samp_cnt_ff == ENTRY_SAMPLE_CNT &&
                    pin_lvl && dbg_en_ff)) ? FLAG_FREEZE : FLAG_IDLE;
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_ENABLE:  rdata_ff <= enable_ff;
        OFS_CAUSE:   rdata_ff <= cause_ff;
        OFS_STATUS:  rdata_ff <= {26'h0, exc_flag_ff, seq_err_ff, dbg_en_ff, status_ff, in_dbg};
        OFS_PORTDAT: rdata_ff <= pd_rdata;
        OFS_MSTATE:  rdata_ff <= {30'h0, mstate_ff};
        default:     rdata_ff <= 32'h0000_0000;
      endcase
    end
    else
      rdata_ff <= 32'h0000_0000;
  end

  // Outputs from flip-flops; fetch and prefetch follow the pipeline flag register
  assign fetch_from_port    = flags_ff[0];
  assign prefetch_off       = flags_ff[1];
  assign port_status        = status_ff;
  assign port_out_data      = pd_rdata;
  assign trap_enable        = trap_ff;
  assign take_exception     = take_exc_ff;
  assign save_context       = save_ff;
  assign instr_to_cpu       = instr_ff;
  assign instr_valid        = instr_vld_ff;
  assign checkstop          = chk_ff;
  assign monitor_freeze     = mon_frz_ff;
  assign pipeline_flag_pins = flags_ff;
  assign reset_vector_go    = go_ff;
  assign reg_rdata          = rdata_ff;

endmodule

// ---- tb/dmc_emu_model.sv ----
// Emulator model: drives the serial clock pin and decoded port words.
// Assumes the bench calls its tasks from one process just after a rising edge.
`timescale 1ns/1ps
module dmc_emu_model
  import dmc_pkg::*;
(
  // Clock
  input  wire logic    clk,
  // Port side
  output logic         pin,
  output dmc_port_in_t word
);
  // Pin low between frames, no word pending
  initial
  begin
    pin  = 1'b0;
    word = '0;
  end

  // Level on the pin around reset; low in time avoids entry
  task automatic hold(input logic v);
    @(posedge clk);
    pin <= v;
  endtask

  // One frame at 800 ns link clock, then the word; data inverted once released
  task automatic send(input dmc_xkind_t k, input logic [31:0] d);
    repeat (8)
    begin
      @(posedge clk);
      pin <= ~pin;
      repeat (3) @(posedge clk);
    end
    word <= '{valid: 1'b1, kind: k, data: d};
    @(posedge clk);
    word <= '{valid: 1'b0, kind: k, data: ~d};
  endtask
endmodule

// ---- tb/dmc_top_assertions.sv ----
// Checker for the debug mode controller, watching top ports only.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/1ps
module dmc_top_assertions
  import dmc_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         resetn,
  // Watched ports
  input wire dmc_port_in_t port_in,
  input wire dmc_cpu_ev_t  cpu_ev,
  input wire logic [1:0]   port_status,
  input wire logic [1:0]   pipeline_flag_pins,
  input wire logic         fetch_from_port,
  input wire logic         prefetch_off,
  input wire logic         take_exception,
  input wire logic         save_context,
  input wire logic         instr_valid,
  input wire logic         checkstop,
  input wire logic         monitor_freeze,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_flag_code;
    pipeline_flag_pins == FLAG_IDLE || pipeline_flag_pins == FLAG_FREEZE;
  endproperty
  a_flag_code: assert property (p_flag_code)
    else $error("flag pins carry an illegal code");

  // Settled freeze, not at the exit edge
  property p_frz_fetch;
    (pipeline_flag_pins == FLAG_FREEZE && !cpu_ev.rfi) [*2] |-> fetch_from_port && prefetch_off;
  endproperty
  a_frz_fetch: assert property (p_frz_fetch)
    else $error("freeze without port fetch");

  property p_rfi_exit;
    pipeline_flag_pins == FLAG_FREEZE && cpu_ev.rfi |-> ##[1:4] pipeline_flag_pins == FLAG_IDLE;
  endproperty
  a_rfi_exit: assert property (p_rfi_exit)
    else $error("freeze kept after return");

  property p_seq_err;
    port_in.valid && port_in.kind != XK_TRAP && pipeline_flag_pins == FLAG_IDLE && !fetch_from_port
      && !checkstop && port_status == ST_NULL |=> port_status == ST_SEQERR;
  endproperty
  a_seq_err: assert property (p_seq_err)
    else $error("no sequence error outside debug");

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without read");

  property p_no_save;
    (pipeline_flag_pins == FLAG_FREEZE) [*2] |-> !take_exception && !save_context;
  endproperty
  a_no_save: assert property (p_no_save)
    else $error("exception taken in debug");

  property p_chk_idle;
    checkstop |-> pipeline_flag_pins == FLAG_IDLE && !take_exception;
  endproperty
  a_chk_idle: assert property (p_chk_idle)
    else $error("checkstop with debug or exception");

  property p_ivalid;
    instr_valid |-> fetch_from_port;
  endproperty
  a_ivalid: assert property (p_ivalid)
    else $error("port instruction outside debug");

  property p_mon;
    monitor_freeze |-> pipeline_flag_pins == FLAG_IDLE;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor freeze in debug");
endmodule

bind dmc_top dmc_top_assertions i_chk (
  .clk(clk), .resetn(resetn), .port_in(port_in), .cpu_ev(cpu_ev), .port_status(port_status),
  .pipeline_flag_pins(pipeline_flag_pins), .fetch_from_port(fetch_from_port), .prefetch_off(prefetch_off),
  .take_exception(take_exception), .save_context(save_context), .instr_valid(instr_valid),
  .checkstop(checkstop), .monitor_freeze(monitor_freeze), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ---- tb/dmc_top_tb.sv ----
// Bench for the debug mode controller with an emulator model on the port.
// Assumes the package, design, model and checker are compiled before it.
`timescale 1ns/1ps
module dmc_top_tb
  import dmc_pkg::*;
  ;
  logic         clk = 1'b0;
  logic         resetn, reset_output, reg_wr, reg_rd, pin, fetch_from_port, prefetch_off;
  logic         take_exception, save_context, instr_valid, checkstop, monitor_freeze, reset_vector_go;
  logic [3:0]   reg_addr;
  logic [31:0]  reg_wdata, cpu_wdata, reg_rdata, instr_to_cpu, port_out_data, rnd, n0;
  logic [31:0]  te_n = 32'h0;
  logic [31:0]  sv_n = 32'h0;
  logic [31:0]  vg_n = 32'h0;
  logic [1:0]   port_status, pipeline_flag_pins;
  logic [6:0]   trap_enable;
  dmc_cpu_ev_t  cpu_ev;
  dmc_port_in_t port_in;
  int           b;
  int           error_cnt = 0;
  int           checks = 0;
  int           seed = 32'h102d;

  // 10 MHz clock
  always #50 clk = ~clk;

  // Pulse counters; pulses last one cycle
  always @(posedge clk)
  begin
    te_n <= te_n + {31'h0, take_exception};
    sv_n <= sv_n + {31'h0, save_context};
    vg_n <= vg_n + {31'h0, reset_vector_go};
  end

  dmc_top i_dmc_top (
    .clk(clk), .resetn(resetn), .reset_output(reset_output), .dev_serial_clock_pin(pin),
    .port_in(port_in), .port_status(port_status), .port_out_data(port_out_data), .trap_enable(trap_enable),
    .cpu_ev(cpu_ev), .cpu_wdata(cpu_wdata), .fetch_from_port(fetch_from_port), .prefetch_off(prefetch_off),
    .take_exception(take_exception), .save_context(save_context), .instr_to_cpu(instr_to_cpu),
    .instr_valid(instr_valid), .checkstop(checkstop), .monitor_freeze(monitor_freeze),
    .pipeline_flag_pins(pipeline_flag_pins), .reset_vector_go(reset_vector_go), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  dmc_emu_model i_dmc_emu_model (.clk(clk), .pin(pin), .word(port_in));

  // Expected cause from the machine-check allow bit
  function automatic logic [31:0] mc_cause(input logic allow);
    return allow ? CAUSE_MCHECK : CAUSE_CHKSTOP;
  endfunction
  function automatic logic [31:0] bit_of(input int n);
    return 32'h1 << n;
  endfunction

  task automatic final_report;
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask

  // Bounded wait for a flag code; a miss ends the run
  task automatic wait_flags(input logic [1:0] v);
    int n;
    n = 0;
    while (pipeline_flag_pins !== v && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk2(pipeline_flag_pins, v);
    if (pipeline_flag_pins !== v)
      final_report;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata & m, exp);
  endtask
  task automatic ev(input dmc_cpu_ev_t e, input int gap);
    @(posedge clk);
    cpu_ev <= e;
    @(posedge clk);
    cpu_ev <= '0;
    repeat (gap) @(posedge clk);
  endtask
  // Pin level p until hold cycles after reset_output falls
  task automatic do_reset(input logic p, input int hold);
    resetn       <= 1'b0;
    reset_output <= 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    i_dmc_emu_model.hold(p);
    repeat (6) @(posedge clk);
    reset_output <= 1'b0;
    repeat (hold) @(posedge clk);
    i_dmc_emu_model.hold(1'b0);
    repeat (20) @(posedge clk);
  endtask

  // Watchdog on the whole run
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    reset_output = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, cpu_wdata} = '0;
    cpu_ev = '0;
    do_reset(1'b0, 2);
    rd(OFS_STATUS, 32'h8, 32'h0);
    rnd = $random(seed);
    wr(4'hf, rnd);
    rd(4'hf, 32'hffff_ffff, 32'h0);
    i_dmc_emu_model.send(XK_INSTR, rnd);
    @(negedge clk);
    chk2(port_status, ST_SEQERR);
    i_dmc_emu_model.send(XK_TRAP, rnd);
    i_dmc_emu_model.send(XK_TRAP, ~rnd);
    @(negedge clk);
    chk2(port_status, ST_NULL);
    chk({25'h0, trap_enable}, {25'h0, ~rnd[6:0]});
    wr(OFS_MSTATE, 32'h2);
    n0 = te_n;
    ev('{mcheck: 1'b1, default: '0}, 4);
    chk(te_n - n0, 32'h1);
    rd(OFS_CAUSE, 32'h3000_0000, mc_cause(1'b1));
    wr(OFS_ENABLE, 32'h20);
    ev('{exc: 1'b1, cause: 32'h20, default: '0}, 4);
    chk({31'h0, monitor_freeze}, 32'h1);
    wr(OFS_MSTATE, 32'h0);
    ev('{mcheck: 1'b1, default: '0}, 4);
    chk({31'h0, checkstop}, 32'h1);
    rd(OFS_CAUSE, 32'h3000_0000, mc_cause(1'b0));
    // Enabled, pin dropped early: normal run
    n0 = vg_n;
    do_reset(1'b1, 2);
    chk(vg_n - n0, 32'h1);
    chk2(pipeline_flag_pins, FLAG_IDLE);
    rd(OFS_STATUS, 32'h8, 32'h8);
    wr(OFS_ENABLE, CAUSE_MCHECK);
    wr(OFS_MSTATE, 32'h3);
    ev('{mcheck: 1'b1, default: '0}, 0);
    wait_flags(FLAG_FREEZE);
    rd(OFS_CAUSE, 32'hffff_ffff, CAUSE_MCHECK);
    rd(OFS_CAUSE, 32'hffff_ffff, 32'h0);
    rnd = $random(seed);
    i_dmc_emu_model.send(XK_INSTR, rnd);
    @(negedge clk);
    chk(instr_to_cpu, rnd);
    chk({31'h0, instr_valid}, 32'h1);
    chk2(port_status, ST_NULL);
    ev('{ext_irq: 1'b1, default: '0}, 2);
    i_dmc_emu_model.send(XK_INSTR, ~rnd);
    @(negedge clk);
    chk2(port_status, ST_EXCEPT);
    cpu_wdata <= $random(seed);
    ev('{port_data_reg_wr: 1'b1, default: '0}, 3);
    chk(port_out_data, cpu_wdata);
    rd(OFS_CAUSE, ~32'h0, 32'h0);
    ev('{rfi: 1'b1, default: '0}, 0);
    wait_flags(FLAG_IDLE);
    // Pin held: entry straight out of reset
    do_reset(1'b1, 30);
    wait_flags(FLAG_FREEZE);
    rd(OFS_CAUSE, 32'hffff_ffff, bit_of(BIT_BRKPT));
    ev('{rfi: 1'b1, default: '0}, 0);
    wait_flags(FLAG_IDLE);
    b = $unsigned($random(seed)) % 16;
    wr(OFS_ENABLE, bit_of(b));
    n0 = sv_n;
    ev('{exc: 1'b1, cause: bit_of(b), default: '0}, 0);
    wait_flags(FLAG_FREEZE);
    rd(OFS_CAUSE, 32'hffff_ffff, bit_of(b));
    chk(sv_n - n0, 32'h1);
    ev('{rfi: 1'b1, default: '0}, 0);
    wait_flags(FLAG_IDLE);
    rd(OFS_STATUS, 32'h8, 32'h8);
    final_report;
  end
endmodule
